/* File: core/taf_checker.sv */
// Adaptation field checker with APB registers
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module taf_checker #(
  parameter int NSLOT = 4
) (
  input wire logic pclk, // 40 MHz system clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic hdr_valid, // Packet header strobe
  input wire logic [$clog2(NSLOT)-1:0] hdr_slot, // PID slot
  input wire logic [1:0] hdr_afc, // Adaptation field control
  input wire logic [3:0] hdr_cc, // Continuity counter
  input wire logic byte_valid, // Byte strobe after header
  input wire logic [7:0] byte_data, // Byte after header
  output logic out_valid, // Pass-through byte strobe
  output logic [7:0] out_data, // Pass-through byte
  output logic stc_restart, // New time base on a PCR slot, pulse
  output logic pkt_err, // Packet broke a constraint, pulse
  output logic drop_hint, // Packet may be discarded, pulse
  output logic prio_out, // Payload has higher priority
  output logic [1:0] ref_exp, // PCR, OPCR fields expected
  output logic [7:0] pay_cnt // Payload byte count
);
  import taf_pkg::*;
  localparam int SW = $clog2(NSLOT);
  if (NSLOT < 2 || NSLOT > 16) begin : g_chk
    $error("NSLOT must be 2 to 16");
  end

  logic ev, has, sh;
  logic [7:0] len, fl;
  logic [SW-1:0] slot_reg, slot_next;
  logic [1:0] afc_reg, afc_next;
  logic [3:0] cc_reg, cc_next;

  taf_af_parser u_parse (
    .pclk(pclk),
    .presetn(presetn),
    .hdr_valid(hdr_valid),
    .hdr_afc(hdr_afc),
    .byte_valid(byte_valid),
    .byte_data(byte_data),
    .af_done(ev),
    .af_has(has),
    .af_len(len),
    .af_flags(fl),
    .af_short(sh)
  );

  // Per-slot history and software state
  logic [3:0] lcc_reg [NSLOT];
  logic [3:0] lcc_next [NSLOT];
  logic [NSLOT-1:0] ccok_reg, ccok_next, jmp_reg, jmp_next, pend_reg, pend_next;
  logic [1:0] drun_reg [NSLOT];
  logic [1:0] drun_next [NSLOT];
  logic [1:0] since_reg [NSLOT];
  logic [1:0] since_next [NSLOT];
  logic [NSLOT-1:0] mask_reg, mask_next, err_reg, err_next, stat;
  logic drop_reg, drop_next;
  logic [7:0] llen_reg, llen_next, lfl_reg, lfl_next;
  logic ov_next, rs_next, pe_next, dh_next, pr_next, rdy_next, se_next;
  logic [1:0] re_next;
  logic [7:0] pc_next;
  logic [31:0] rd_next;
  logic disc, pcrp, pcrf, pay, dup, cont, tb, bad, len_bad;
  logic [8:0] tot;

  // Packet checks, evaluated once the field head is known
  always_comb begin
    slot_next = hdr_valid ? hdr_slot : slot_reg;
    afc_next = hdr_valid ? hdr_afc : afc_reg;
    cc_next = hdr_valid ? hdr_cc : cc_reg;
    lcc_next = lcc_reg;
    ccok_next = ccok_reg;
    jmp_next = jmp_reg;
    pend_next = pend_reg;
    drun_next = drun_reg;
    since_next = since_reg;
    llen_next = llen_reg;
    lfl_next = lfl_reg;
    rs_next = 1'b0;
    pe_next = 1'b0;
    dh_next = 1'b0;
    pr_next = prio_out;
    re_next = ref_exp;
    pc_next = pay_cnt;
    disc = fl[TAF_B_DISC];
    pcrp = mask_reg[slot_reg];
    pcrf = fl[TAF_B_PCR];
    pay = afc_reg[0];
    tb = pcrp && disc && pcrf;
    dup = ccok_reg[slot_reg] && pay && cc_reg == lcc_reg[slot_reg];
    // Counter holds without payload; duplicates count as continuous
    cont = !ccok_reg[slot_reg] || dup
      || cc_reg == (pay ? 4'(lcc_reg[slot_reg] + 4'h1) : lcc_reg[slot_reg]);
    len_bad = (afc_reg == TAF_AFC_BOTH && len > TAF_LEN_MIX_MAX)
      || (afc_reg == TAF_AFC_AF && len != TAF_LEN_ONLY) || sh;
    bad = len_bad
      || (!cont && !(disc && (!pcrp || tb)))
      || (!cont && disc && jmp_reg[slot_reg])
      || (!pcrp && disc && drun_reg[slot_reg] == TAF_DISC_MAX)
      || (pcrp && pend_reg[slot_reg] && !disc)
      || (tb && since_reg[slot_reg] < TAF_PCR_GOAL)
      || (fl[TAF_B_RAI] && pcrp && !pcrf);
    tot = has ? 9'(len + 9'h001) : 9'h000;
    if (ev) begin
      lcc_next[slot_reg] = cc_reg;
      ccok_next[slot_reg] = 1'b1;
      jmp_next[slot_reg] = disc && (jmp_reg[slot_reg] || !cont);
      drun_next[slot_reg] = !disc ? 2'h0 : (drun_reg[slot_reg] == 2'h3 ? 2'h3
        : 2'(drun_reg[slot_reg] + 2'h1));
      if (tb) pend_next[slot_reg] = 1'b0;
      else if (pcrp && disc) pend_next[slot_reg] = 1'b1;
      if (tb) since_next[slot_reg] = 2'h1;
      else if (pcrp && pcrf && since_reg[slot_reg] != TAF_PCR_GOAL)
        since_next[slot_reg] = 2'(since_reg[slot_reg] + 2'h1);
      rs_next = tb;
      pe_next = bad;
      dh_next = drop_reg && disc && dup;
      pr_next = fl[TAF_B_PRIO];
      re_next = {fl[TAF_B_PCR], fl[TAF_B_OPCR]};
      pc_next = tot > TAF_PAYLOAD ? 8'h00 : 8'(TAF_PAYLOAD - tot);
      llen_next = len;
      lfl_next = fl;
    end
    ov_next = byte_valid;
  end

  // Discontinuity state per slot for status reads
  for (genvar i = 0; i < NSLOT; i++) begin : g_stat
    assign stat[i] = drun_reg[i] != 2'h0;
  end

  // APB slave: no wait state; pready and data come from flops loaded in the setup phase
  always_comb begin
    rdy_next = psel && !penable;
    se_next = 1'b0;
    rd_next = 32'h0;
    mask_next = mask_reg;
    drop_next = drop_reg;
    err_next = err_reg;
    case (paddr)
      TAF_OFF_CTRL: begin
        rd_next[NSLOT-1:0] = mask_reg;
        rd_next[TAF_CTRL_DROP] = drop_reg;
      end
      TAF_OFF_ERR: rd_next[NSLOT-1:0] = err_reg;
      TAF_OFF_STAT: rd_next[NSLOT-1:0] = stat;
      TAF_OFF_LAST: rd_next = {8'h00, lfl_reg, pay_cnt, llen_reg};
      default: se_next = 1'b1;
    endcase
    if (psel && penable && pready && pwrite) begin
      if (paddr == TAF_OFF_CTRL) begin
        mask_next = pwdata[NSLOT-1:0];
        drop_next = pwdata[TAF_CTRL_DROP];
      end
      // Write one to clear
      if (paddr == TAF_OFF_ERR) err_next = err_reg & ~pwdata[NSLOT-1:0];
    end
    // A new error beats a clear in the same cycle
    if (ev && bad) err_next[slot_reg] = 1'b1;
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_reg <= '0;
      afc_reg <= 2'h0;
      cc_reg <= 4'h0;
      for (int i = 0; i < NSLOT; i++) begin
        lcc_reg[i] <= 4'h0;
        drun_reg[i] <= 2'h0;
        since_reg[i] <= TAF_PCR_GOAL;
      end
      ccok_reg <= '0;
      jmp_reg <= '0;
      pend_reg <= '0;
      mask_reg <= TAF_CTRL_RST[NSLOT-1:0];
      drop_reg <= 1'b0;
      err_reg <= '0;
      llen_reg <= 8'h00;
      lfl_reg <= 8'h00;
      out_valid <= 1'b0;
      out_data <= 8'h00;
      stc_restart <= 1'b0;
      pkt_err <= 1'b0;
      drop_hint <= 1'b0;
      prio_out <= 1'b0;
      ref_exp <= 2'h0;
      pay_cnt <= 8'h00;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      slot_reg <= slot_next;
      afc_reg <= afc_next;
      cc_reg <= cc_next;
      lcc_reg <= lcc_next;
      drun_reg <= drun_next;
      since_reg <= since_next;
      ccok_reg <= ccok_next;
      jmp_reg <= jmp_next;
      pend_reg <= pend_next;
      mask_reg <= mask_next;
      drop_reg <= drop_next;
      err_reg <= err_next;
      llen_reg <= llen_next;
      lfl_reg <= lfl_next;
      out_valid <= ov_next;
      out_data <= byte_data;
      stc_restart <= rs_next;
      pkt_err <= pe_next;
      drop_hint <= dh_next;
      prio_out <= pr_next;
      ref_exp <= re_next;
      pay_cnt <= pc_next;
      pready <= rdy_next;
      pslverr <= rdy_next && se_next;
      prdata <= rdy_next ? rd_next : 32'h0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence tb_pkt;
    ev && tb;
  endsequence
  restart_pulse_a: assert property (tb_pkt |=> stc_restart ##1 !stc_restart)
    else $error("time base change not signalled");
  len_mix_a: assert property (
    ev && afc_reg == TAF_AFC_BOTH && len > TAF_LEN_MIX_MAX |=> pkt_err)
    else $error("oversized field length not flagged");
  len_only_a: assert property (
    ev && afc_reg == TAF_AFC_AF && len != TAF_LEN_ONLY |=> pkt_err)
    else $error("field-only length not flagged");
  rai_pcr_a: assert property (
    ev && fl[TAF_B_RAI] && pcrp && !pcrf |=> pkt_err)
    else $error("random access without PCR not flagged");
  pay_count_a: assert property (
    ev && afc_reg == TAF_AFC_BOTH && len <= TAF_LEN_MIX_MAX
    |=> pay_cnt == 8'(TAF_PAYLOAD - 9'($past(len)) - 9'h001))
    else $error("payload count wrong");
  triple_disc_a: assert property (
    ev && disc && !pcrp && drun_reg[slot_reg] == TAF_DISC_MAX |=> pkt_err)
    else $error("third indicator not flagged");
  err_sticky_a: assert property (
    ev && bad |=> err_reg[$past(slot_reg)] ##1 pkt_err == 1'b0)
    else $error("error bit not latched");
  pass_thru_a: assert property (
    byte_valid |=> out_valid && out_data == $past(byte_data))
    else $error("byte not passed unchanged");
endmodule
`default_nettype wire

/* File: common/taf_pkg.sv */
// Shared constants for the adaptation field checker
package taf_pkg;
  // Adaptation field control codes
  localparam logic [1:0] TAF_AFC_NONE = 2'h0;
  localparam logic [1:0] TAF_AFC_PAY = 2'h1;
  localparam logic [1:0] TAF_AFC_AF = 2'h2;
  localparam logic [1:0] TAF_AFC_BOTH = 2'h3;
  // Length limits and packet payload room
  localparam logic [7:0] TAF_LEN_MIX_MAX = 8'hb6;
  localparam logic [7:0] TAF_LEN_ONLY = 8'hb7;
  localparam logic [8:0] TAF_PAYLOAD = 9'hb8;
  localparam logic [7:0] TAF_CLKREF_BYTES = 8'h06;
  // Flag bit positions in the flags byte
  localparam int TAF_B_DISC = 7;
  localparam int TAF_B_RAI = 6;
  localparam int TAF_B_PRIO = 5;
  localparam int TAF_B_PCR = 4;
  localparam int TAF_B_OPCR = 3;
  // PCRs of a new time base needed before another change; run of indicators allowed off the PCR slot
  localparam logic [1:0] TAF_PCR_GOAL = 2'h2;
  localparam logic [1:0] TAF_DISC_MAX = 2'h2;
  // Register byte offsets, control drop bit position and control reset value
  localparam logic [7:0] TAF_OFF_CTRL = 8'h00;
  localparam logic [7:0] TAF_OFF_ERR = 8'h04;
  localparam logic [7:0] TAF_OFF_STAT = 8'h08;
  localparam logic [7:0] TAF_OFF_LAST = 8'h0c;
  localparam int TAF_CTRL_DROP = 16;
  localparam logic [15:0] TAF_CTRL_RST = 16'h0000;
  // Parser states
  typedef enum logic [1:0] {
    TAF_P_IDLE = 2'b00,
    TAF_P_LEN = 2'b01,
    TAF_P_FLAGS = 2'b10
  } taf_pst_e;
endpackage

/* File: core/taf_af_parser.sv */
// Parser for the length byte and flags byte of an adaptation field
`timescale 1ns/100ps
`default_nettype none
module taf_af_parser (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic hdr_valid, // Packet header strobe
  input wire logic [1:0] hdr_afc, // Adaptation field control
  input wire logic byte_valid, // Payload region byte strobe
  input wire logic [7:0] byte_data, // Payload region byte
  output logic af_done, // Field head decoded, one cycle
  output logic af_has, // Field present
  output logic [7:0] af_len, // Length byte
  output logic [7:0] af_flags, // Flags, zero when absent
  output logic af_short // Length too small for clock refs
);
  import taf_pkg::*;
  taf_pst_e st_reg, st_next;
  logic done_next, has_next, short_next;
  logic [7:0] len_next, flags_next;
  logic [7:0] need;

  // Walk length byte then flags byte; later bytes are not decoded
  always_comb begin
    st_next = st_reg;
    done_next = 1'b0;
    has_next = af_has;
    len_next = af_len;
    flags_next = af_flags;
    short_next = af_short;
    need = 8'h01;
    if (byte_data[TAF_B_PCR]) need = 8'(need + TAF_CLKREF_BYTES);
    if (byte_data[TAF_B_OPCR]) need = 8'(need + TAF_CLKREF_BYTES);
    case (st_reg)
      TAF_P_IDLE: begin
        if (hdr_valid) begin
          flags_next = 8'h00;
          short_next = 1'b0;
          len_next = 8'h00;
          has_next = hdr_afc[1];
          if (hdr_afc[1]) st_next = TAF_P_LEN;
          else done_next = 1'b1;
        end
      end
      TAF_P_LEN: begin
        if (byte_valid) begin
          len_next = byte_data;
          if (byte_data == 8'h00) begin
            done_next = 1'b1;
            st_next = TAF_P_IDLE;
          end else st_next = TAF_P_FLAGS;
        end
      end
      TAF_P_FLAGS: begin
        if (byte_valid) begin
          flags_next = byte_data;
          short_next = af_len < need;
          done_next = 1'b1;
          st_next = TAF_P_IDLE;
        end
      end
      default: st_next = TAF_P_IDLE;
    endcase
  end

  // Parser registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= TAF_P_IDLE;
      af_done <= 1'b0;
      af_has <= 1'b0;
      af_len <= 8'h00;
      af_flags <= 8'h00;
      af_short <= 1'b0;
    end else begin
      st_reg <= st_next;
      af_done <= done_next;
      af_has <= has_next;
      af_len <= len_next;
      af_flags <= flags_next;
      af_short <= short_next;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  zero_len_a: assert property (
    st_reg == TAF_P_LEN && byte_valid && byte_data == 8'h00
    |=> af_done && af_flags == 8'h00 && af_len == 8'h00)
    else $error("zero length did not end field");
  flags_take_a: assert property (
    st_reg == TAF_P_FLAGS && byte_valid
    |=> af_done && af_flags == $past(byte_data))
    else $error("flags byte not captured");
endmodule
`default_nettype wire

/* File: tb/taf_mux_model.sv */
// Behavioural multiplexer model that emits one packet per request
`timescale 1ns/100ps
`default_nettype none
module taf_mux_model (
  input wire logic pclk, // System clock
  input wire logic go, // Start one packet
  input wire logic [1:0] slot, // PID slot
  input wire logic [1:0] afc, // Field control
  input wire logic [3:0] cc, // Counter value
  input wire logic [7:0] len, // Field length
  input wire logic [7:0] flags, // Flags byte
  output logic busy = 1'b0, // Packet in flight
  output logic hdr_valid = 1'b0, // Header strobe
  output logic [1:0] hdr_slot = 2'h0, // Header slot
  output logic [1:0] hdr_afc = 2'h0, // Header control
  output logic [3:0] hdr_cc = 4'h0, // Header counter
  output logic byte_valid = 1'b0, // Byte strobe
  output logic [7:0] byte_data = 8'h00 // Byte value
);
  int i;
  // Header then 184 bytes back to back; released bus shows inverted data
  always @(posedge pclk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      hdr_valid <= 1'b1;
      hdr_slot <= slot;
      hdr_afc <= afc;
      hdr_cc <= cc;
      for (i = 0; i < 184; i++) begin
        @(posedge pclk);
        hdr_valid <= 1'b0;
        byte_valid <= 1'b1;
        if (afc[1] && i == 0) begin
          byte_data <= len;
        end else if (afc[1] && i == 1 && len != 8'h00) begin
          byte_data <= flags;
        end else if (afc[1] && i <= len) begin
          byte_data <= 8'hff;
        end else begin
          byte_data <= i[7:0]; // Counting payload, no PES or PSI
        end
      end
      @(posedge pclk);
      byte_valid <= 1'b0;
      byte_data <= ~byte_data;
      busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb_ts_adaptation_field_checker.sv */
// Self-checking bench for the adaptation field checker
`timescale 1ns/100ps
`default_nettype none
module tb_ts_adaptation_field_checker;
  import taf_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0, busy, pe, pslverr, pready;
  logic [7:0] paddr = 8'h00, m_len = 8'h00, m_flags = 8'h00, byte_data, out_data, pay_cnt;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [1:0] m_slot = 2'h0, m_afc = 2'h0, hdr_slot, hdr_afc, ref_exp;
  logic [3:0] m_cc = 4'h0, hdr_cc;
  logic [3:0] ccs [4] = '{4'h0, 4'h0, 4'h0, 4'h0};
  logic [2:0] seen = 3'h0;
  logic hdr_valid, byte_valid, out_valid, stc_restart, pkt_err, drop_hint, prio_out;
  // Each entry: control, length, flags, expected error bit
  logic [23:0] tbl [12] = '{24'h3_00_00_0, 24'h3_b6_00_0, 24'h3_b7_00_1, 24'h2_b7_00_0,
    24'h2_b6_00_1, 24'h1_00_00_0, 24'h3_07_10_0, 24'h3_06_10_1, 24'h3_0d_18_0,
    24'h3_0c_18_1, 24'h3_01_20_0, 24'h0_00_00_0};
  int fail_count = 0, num_checks = 0, k, seed = 32'hc4a6;
  logic [7:0] rl, rf;
  always #12.5 pclk = ~pclk;
  taf_mux_model mux (.pclk, .go, .slot(m_slot), .afc(m_afc), .cc(m_cc), .len(m_len),
    .flags(m_flags), .busy, .hdr_valid, .hdr_slot, .hdr_afc, .hdr_cc, .byte_valid, .byte_data);
  taf_checker #(.NSLOT(4)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .hdr_valid, .hdr_slot, .hdr_afc, .hdr_cc, .byte_valid,
    .byte_data, .out_valid, .out_data, .stc_restart, .pkt_err, .drop_hint, .prio_out,
    .ref_exp, .pay_cnt);
  // Pass-through: every byte reappears unchanged one cycle later
  logic [8:0] ocnt = 9'h000;
  logic [7:0] last_b = 8'h00;
  logic last_v = 1'b0;
  always @(posedge pclk) begin
    last_v <= byte_valid;
    last_b <= byte_data;
    ocnt <= go ? 9'h000 : 9'(ocnt + {8'h00, out_valid});
    if (last_v || out_valid) begin
      chk({23'h0, out_valid, out_data}, {23'h0, 1'b1, last_b});
    end
  end
  // Catch one-cycle pulses over a whole packet
  always @(posedge pclk) seen <= go ? 3'h0 : seen | {drop_hint, stc_restart, pkt_err};
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits for pready without assuming a latency
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    pe = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Levels expected after a packet: priority, PCR, OPCR, payload count
  function automatic logic [10:0] lvl(input logic [1:0] a, input logic [7:0] l, f);
    logic [7:0] g;
    logic [7:0] p;
    g = (a[1] && l != 8'h00) ? f : 8'h00;
    p = !a[1] ? TAF_PAYLOAD[7:0] : (l > TAF_LEN_ONLY) ? 8'h00 : TAF_LEN_ONLY - l;
    return {g[TAF_B_PRIO], g[TAF_B_PCR], g[TAF_B_OPCR], p};
  endfunction
  // Send one packet, counter advanced by the bench plus a jump j
  task automatic pkt(input logic [1:0] s, a, input logic [7:0] l, f, input logic [3:0] j,
    input logic [2:0] exp, msk);
    ccs[s] = ccs[s] + j + {3'h0, a[0]};
    m_slot <= s;
    m_afc <= a;
    m_cc <= ccs[s];
    m_len <= l;
    m_flags <= f;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    while (busy === 1'b1) @(posedge pclk);
    repeat (3) @(posedge pclk);
    chk({29'h0, seen & msk}, {29'h0, exp & msk});
    chk({21'h0, prio_out, ref_exp, pay_cnt}, {21'h0, lvl(a, l, f)});
    chk({23'h0, ocnt}, {23'h0, TAF_PAYLOAD});
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the roughly 13000 cycles the tests need
  initial begin
    repeat (40000) @(posedge pclk);
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, TAF_OFF_CTRL, 32'h0001_0001);
    apb(1'b0, TAF_OFF_CTRL, 32'h0);
    chk(q, 32'h0001_0001);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, pe}, 32'h1);
    $display("test registers done");
    // Length and flag cases on a plain slot
    for (k = 0; k < 12; k++) pkt(2'h1, tbl[k][21:20], tbl[k][19:12], tbl[k][11:4], 4'h0,
      {2'h0, tbl[k][0]}, 3'h1);
    $display("test lengths done");
    // Counter discontinuities on a plain slot
    pkt(2'h2, 2'h3, 8'h00, 8'h00, 4'h0, 3'h0, 3'h1);
    pkt(2'h2, 2'h3, 8'h01, 8'h80, 4'h3, 3'h0, 3'h1);
    apb(1'b0, TAF_OFF_STAT, 32'h0);
    chk(q, 32'h4);
    pkt(2'h2, 2'h3, 8'h01, 8'h80, 4'h3, 3'h1, 3'h1);
    pkt(2'h2, 2'h3, 8'h01, 8'h80, 4'h0, 3'h1, 3'h1);
    pkt(2'h2, 2'h3, 8'h01, 8'h00, 4'h3, 3'h1, 3'h1);
    $display("test counter done");
    // Time-base changes on the PCR slot
    pkt(2'h0, 2'h3, 8'h01, 8'h80, 4'h0, 3'h0, 3'h3);
    pkt(2'h0, 2'h3, 8'h01, 8'h00, 4'h0, 3'h1, 3'h1);
    pkt(2'h0, 2'h3, 8'h07, 8'h90, 4'h5, 3'h2, 3'h3);
    pkt(2'h0, 2'h3, 8'h07, 8'h90, 4'h0, 3'h1, 3'h1);
    pkt(2'h0, 2'h3, 8'h07, 8'h10, 4'h0, 3'h0, 3'h1);
    pkt(2'h0, 2'h3, 8'h07, 8'h10, 4'h0, 3'h0, 3'h1);
    pkt(2'h0, 2'h3, 8'h07, 8'h90, 4'h0, 3'h2, 3'h3);
    pkt(2'h0, 2'h3, 8'h01, 8'h80, 4'h3, 3'h1, 3'h1);
    pkt(2'h0, 2'h3, 8'h01, 8'hc0, 4'h0, 3'h1, 3'h1);
    $display("test time base done");
    // Duplicate under discontinuity with drop enabled
    pkt(2'h3, 2'h3, 8'h01, 8'h80, 4'h0, 3'h0, 3'h5);
    pkt(2'h3, 2'h3, 8'h01, 8'h80, 4'hf, 3'h4, 3'h5);
    apb(1'b0, TAF_OFF_ERR, 32'h0);
    chk(q, 32'h7);
    apb(1'b1, TAF_OFF_ERR, 32'hffff_ffff);
    apb(1'b0, TAF_OFF_ERR, 32'h0);
    chk(q, 32'h0);
    $display("test duplicate done");
    // Random legal fields on a plain slot
    for (k = 0; k < 40; k++) begin
      rl = 8'($unsigned($random(seed)) % 183);
      rf = 8'($random(seed)) & 8'h7f;
      if (rl < 8'h0d) rf = rf & 8'h67;
      pkt(2'h1, 2'h3, rl, rf, 4'h0, 3'h0, 3'h1);
    end
    $display("test random done");
    print_verdict();
  end
endmodule
`default_nettype wire
